/* File: rtl/dsl_serial_dac.sv */
// frame fifo and serial load front end of a dual 10-bit converter
// assumes: one ahb-lite master, pins asynchronous to hclk, sclk far
// slower than hclk so every link edge is seen after synchronising
//
// Operation
// - shift serial_in on each falling serial clock edge in a frame; edges are counted but not shifted while pend is set
// - after frame sync falls, the next 24 falling edges form one frame
// - input shift register is exactly 24 bits wide
// - serial_out changes at rising clock edge, read at next falling
// - serial_out passes shifted data on for daisy chain or readback
// - load strobe low pulse copies fresh input codes to dac codes
// - load strobe works pulsed or held permanently low
// - gain select low gives span to reference, high twice that
// - reset pin acts on its falling edge, not its level
// - while reset pin low every load strobe is ignored
// - reset loads input and dac codes with zero or midscale
// - power up gives zero scale if select low, midscale if high
// - power-on init waits until reset pin is released high
// - after power up the reference pin is driven as output
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "dsl_params.svh"

module dsl_fifo #(
  parameter int WIDTH = `DSL_FRAME_BITS,
  parameter int DEPTH = `DSL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module dsl_serial_dac (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial link pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_in,
  output logic serial_out,
  // control pins
  input wire logic dac_load_strobe_n,
  input wire logic dac_reset_n,
  input wire logic reset_level_select,
  input wire logic gain_select,
  // converter side
  output logic [`DSL_DAC_BITS-1:0] channel_a_output,
  output logic [`DSL_DAC_BITS-1:0] channel_b_output,
  output logic span_double,
  output logic ref_drive_en
);
  import dsl_pkg::*;

  localparam int CW = $clog2(`DSL_FIFO_DEPTH + 1);

  // pin synchroniser, third stage only for edge finding
  dsl_pins_type pin_meta;
  dsl_pins_type pin_sync;
  dsl_pins_type pin_prev;
  dsl_pins_type pin_raw;
  assign pin_raw = '{sclk: sclk, sync_n: sync_n, sdata: serial_in,
                     load_n: dac_load_strobe_n, reset_n: dac_reset_n,
                     rst_sel: reset_level_select, gain: gain_select};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= '{sync_n: 1'b1, load_n: 1'b1, default: 1'b0};
      pin_sync <= '{sync_n: 1'b1, load_n: 1'b1, default: 1'b0};
      pin_prev <= '{sync_n: 1'b1, load_n: 1'b1, default: 1'b0};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire sclk_fall = pin_prev.sclk & ~pin_sync.sclk;
  wire sclk_rise = ~pin_prev.sclk & pin_sync.sclk;
  wire frame_start = pin_prev.sync_n & ~pin_sync.sync_n;
  wire frame_on = ~pin_sync.sync_n;
  wire load_fall = pin_prev.load_n & ~pin_sync.load_n;
  wire load_low = ~pin_sync.load_n;
  wire rst_fall = pin_prev.reset_n & ~pin_sync.reset_n;
  wire rst_low = ~pin_sync.reset_n;

  // serial frame capture
  logic [`DSL_FRAME_BITS-1:0] shreg;
  logic [4:0] bit_cnt;
  logic pend;
  dsl_frame_type pend_word;
  logic ovf;
  logic fifo_in_ready;
  wire [`DSL_FRAME_BITS-1:0] next_shreg = {shreg[22:0], pin_sync.sdata};
  wire bit_take = frame_on & sclk_fall & (bit_cnt != `DSL_BIT_LAST);
  wire shift_en = bit_take & ~pend;
  wire frame_done = shift_en & (bit_cnt == `DSL_BIT_LAST - 5'd1);
  wire frame_refused = bit_take & pend;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shreg <= '0;
      bit_cnt <= '0;
      serial_out <= 1'b0;
    end else begin
      if (frame_start) begin
        bit_cnt <= '0;
      end else if (bit_take) begin
        bit_cnt <= bit_cnt + 5'd1;
      end
      if (shift_en) begin
        shreg <= next_shreg;
      end
      if (frame_on && sclk_rise) begin
        serial_out <= shreg[`DSL_FRAME_BITS-1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      pend_word <= '0;
    end else if (frame_done) begin
      pend <= 1'b1;
      pend_word <= next_shreg;
    end else if (fifo_in_ready) begin
      pend <= 1'b0;
    end
  end

  // frame queue, draining stalls under software hold
  logic ext_ref;
  logic hold;
  logic fifo_out_valid;
  dsl_frame_type fifo_word;
  logic [CW-1:0] fifo_count;
  wire pop = fifo_out_valid & ~hold;

  dsl_fifo #(
    .WIDTH(`DSL_FRAME_BITS),
    .DEPTH(`DSL_FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(pend),
    .in_data(pend_word),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_word),
    .out_ready(~hold),
    .count(fifo_count)
  );

  // reset pin and power-on handling
  logic por_done;
  wire por_load = ~por_done & pin_sync.reset_n;
  wire reset_load = rst_fall | por_load;
  wire load_ok = ~rst_low & por_done;
  wire [`DSL_DAC_BITS-1:0] rst_val =
    pin_sync.rst_sel ? `DSL_MID_SCALE : `DSL_ZERO_SCALE;
  wire [`DSL_DAC_BITS-1:0] wr_code = fifo_word.data[15:6];
  wire wr_a = pop & fifo_word.addr[`DSL_ADDR_BIT_A];
  wire wr_b = pop & fifo_word.addr[`DSL_ADDR_BIT_B];
  wire xfer = load_fall & load_ok;
  wire auto_load = load_low & load_ok;

  // every strobe term is an argument so the continuous assign
  // re-evaluates when only the strobe moves
  function automatic dsl_chan_type chan_next(
    input dsl_chan_type c,
    input logic wr,
    input logic [`DSL_DAC_BITS-1:0] code,
    input logic rst,
    input logic [`DSL_DAC_BITS-1:0] rv,
    input logic ld,
    input logic al
  );
    dsl_chan_type n;
    n = c;
    if (rst) begin
      n = '{in_code: rv, dac_code: rv, fresh: 1'b0};
    end else begin
      if (ld && c.fresh) begin
        n.dac_code = c.in_code;
        n.fresh = 1'b0;
      end
      if (wr) begin
        n.in_code = code;
        n.fresh = ~al;
        if (al) begin
          n.dac_code = code;
        end
      end
    end
    chan_next = n;
  endfunction

  dsl_chan_type chan_a;
  dsl_chan_type chan_b;
  wire dsl_chan_type next_chan_a =
    chan_next(chan_a, wr_a, wr_code, reset_load, rst_val,
              xfer, auto_load);
  wire dsl_chan_type next_chan_b =
    chan_next(chan_b, wr_b, wr_code, reset_load, rst_val,
              xfer, auto_load);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_a <= '0;
      chan_b <= '0;
      por_done <= 1'b0;
      channel_a_output <= `DSL_ZERO_SCALE;
      channel_b_output <= `DSL_ZERO_SCALE;
    end else begin
      chan_a <= next_chan_a;
      chan_b <= next_chan_b;
      channel_a_output <= next_chan_a.dac_code;
      channel_b_output <= next_chan_b.dac_code;
      if (por_load) begin
        por_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      span_double <= 1'b0;
      ref_drive_en <= 1'b1;
    end else begin
      span_double <= pin_sync.gain;
      ref_drive_en <= ~ext_ref;
    end
  end

  // ahb-lite slave, one wait state per transfer
  logic ph_act;
  logic ph_write;
  logic ph_word;
  logic [7:0] ph_addr;
  wire take = hsel & htrans[1] & hready;
  wire hit_ctrl = (ph_addr == `DSL_REG_CTRL);
  wire hit_stat = (ph_addr == `DSL_REG_STATUS);
  wire hit_a = (ph_addr == `DSL_REG_CHAN_A);
  wire hit_b = (ph_addr == `DSL_REG_CHAN_B);
  wire wr_en = ph_act & ph_write & ph_word;
  wire ovf_clr = wr_en & hit_stat & hwdata[`DSL_STAT_OVF];
  wire [31:0] ctrl_word = {30'h0, hold, ext_ref};
  wire [31:0] stat_word = {20'h0, (4)'(fifo_count), 4'h0,
                           pend, por_done, rst_low, ovf};
  wire [31:0] a_word = {chan_a.fresh, 5'h0, chan_a.dac_code,
                        6'h0, chan_a.in_code};
  wire [31:0] b_word = {chan_b.fresh, 5'h0, chan_b.dac_code,
                        6'h0, chan_b.in_code};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_stat ? stat_word :
                        hit_a ? a_word :
                        hit_b ? b_word : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_act <= 1'b0;
      ph_write <= 1'b0;
      ph_word <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else if (ph_act) begin
      ph_act <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= ph_write ? 32'h0 : rd_word;
    end else if (take) begin
      ph_act <= 1'b1;
      ph_write <= hwrite;
      ph_word <= (hsize == `DSL_HSIZE_WORD);
      ph_addr <= haddr[7:0];
      hreadyout <= 1'b0;
    end
  end

  // control bits and sticky overflow, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ref <= 1'b0;
      hold <= 1'b0;
      ovf <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        ext_ref <= hwdata[`DSL_CTRL_EXT_REF];
        hold <= hwdata[`DSL_CTRL_HOLD];
      end
      ovf <= frame_refused | (ovf & ~ovf_clr);
    end
  end
endmodule

/* File: rtl/dsl_params.svh */
// constants of the dual converter serial load front end
// assumes: included by the package and by the design file
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH
`define DSL_FRAME_BITS 24
`define DSL_DAC_BITS 10
`define DSL_FIFO_DEPTH 8
`define DSL_BIT_LAST 5'd24
`define DSL_REG_CTRL 8'h00
`define DSL_REG_STATUS 8'h04
`define DSL_REG_CHAN_A 8'h08
`define DSL_REG_CHAN_B 8'h0c
`define DSL_CTRL_EXT_REF 0
`define DSL_CTRL_HOLD 1
`define DSL_STAT_OVF 0
`define DSL_STAT_RST_LOW 1
`define DSL_STAT_POR_DONE 2
`define DSL_STAT_PEND 3
`define DSL_STAT_CNT_LSB 8
`define DSL_ADDR_BIT_A 0
`define DSL_ADDR_BIT_B 3
`define DSL_ZERO_SCALE 10'h000
`define DSL_MID_SCALE 10'h200
`define DSL_HSIZE_WORD 3'h2
`endif

/* File: rtl/dsl_pkg.sv */
// types of the dual converter serial load front end
// assumes: dsl_params.svh sits beside it on the include path
`include "dsl_params.svh"
package dsl_pkg;
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } dsl_frame_type;
  typedef struct packed {
    logic [`DSL_DAC_BITS-1:0] in_code;
    logic [`DSL_DAC_BITS-1:0] dac_code;
    logic fresh;
  } dsl_chan_type;
  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic sdata;
    logic load_n;
    logic reset_n;
    logic rst_sel;
    logic gain;
  } dsl_pins_type;
endpackage

/* File: verif/dsl_host.sv */
// spi host model driving frame sync, link clock and serial data
// assumes: link clock idles high between frames, one frame per call
`timescale 1ns/10ps
module dsl_host (
  // link pins
  output logic sclk,
  output logic sync_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic send(input logic [23:0] w, input int n,
                      output logic [23:0] got);
    sync_n <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      serial_in <= w[i];
      #175 sclk <= 1'b0;
      got[i] = serial_out;
      #125 sclk <= 1'b1;
      #100;
    end
    sync_n <= 1'b1;
    serial_in <= ~serial_in;
    #300;
  endtask
endmodule

/* File: verif/dsl_serial_dac_chk.sv */
// assertions on the serial load front end ports
// assumes: bound into dsl_serial_dac, pins synchronised in 3 hclk
`timescale 1ns/10ps
`include "dsl_params.svh"
module dsl_serial_dac_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic dac_reset_n,
  input wire logic reset_level_select,
  input wire logic gain_select,
  input wire logic [`DSL_DAC_BITS-1:0] channel_a_output,
  input wire logic [`DSL_DAC_BITS-1:0] channel_b_output,
  input wire logic span_double,
  input wire logic ref_drive_en
);
  wire logic [`DSL_DAC_BITS-1:0] rst_code;
  assign rst_code = reset_level_select ? `DSL_MID_SCALE : `DSL_ZERO_SCALE;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ack;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_rst_code;
    channel_a_output == rst_code && channel_b_output == rst_code;
  endsequence
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_ack_slot: assert property (hsel && htrans[1] && hready |=> s_ack)
    else $error("ready not low for one cycle");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |->
    $stable(hrdata)) else $error("read data moved while idle");
  a_span_gain: assert property ($stable(gain_select) [*6] |->
    span_double == gain_select) else $error("span not following gain");
  a_load_block: assert property (!dac_reset_n [*8] |=>
    $stable(channel_a_output) && $stable(channel_b_output))
    else $error("output moved while reset pin low");
  a_reset_load: assert property ($fell(dac_reset_n) |->
    ##[2:8] s_rst_code) else $error("reset value not loaded");
  a_ref_default: assert property (!$past(hresetn) |->
    ref_drive_en) else $error("reference not driven after reset");
  a_sdo_rise: assert property ($changed(serial_out) |->
    $past(sclk, 2)) else $error("serial out moved off rising edge");
endmodule
bind dsl_serial_dac dsl_serial_dac_chk chk_u (.hclk, .hresetn, .hsel,
  .htrans, .hready, .hrdata, .hreadyout, .hresp, .sclk, .serial_out,
  .dac_reset_n, .reset_level_select, .gain_select, .channel_a_output,
  .channel_b_output, .span_double, .ref_drive_en);

/* File: verif/tb.sv */
// self-checking bench for the serial load front end
// assumes: host model on the link pins, one ahb master task set here
`timescale 1ns/10ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic sclk, sync_n, serial_in, serial_out, span_double, ref_drive_en;
  logic dac_load_strobe_n, dac_reset_n, reset_level_select, gain_select;
  logic [9:0] channel_a_output, channel_b_output;
  logic [23:0] got;
  int fails, cmp_count;
  assign hready = hreadyout;
  dsl_serial_dac dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sclk, .sync_n,
    .serial_in, .serial_out, .dac_load_strobe_n, .dac_reset_n,
    .reset_level_select, .gain_select, .channel_a_output,
    .channel_b_output, .span_double, .ref_drive_en);
  dsl_host host_u (.sclk, .sync_n, .serial_in, .serial_out);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task chan(input logic [9:0] a, input logic [9:0] b);
    chk("ch_a", {22'h0, a}, {22'h0, channel_a_output});
    chk("ch_b", {22'h0, b}, {22'h0, channel_b_output});
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    i = 0;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      test_done;
    end else begin
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      i = 0;
      do begin
        @(posedge hclk);
        i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1) begin
        fails++;
        test_done;
      end else begin
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
      end
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  task pulse;
    dac_load_strobe_n <= 1'b0;
    w(2);
    dac_load_strobe_n <= 1'b1;
    w(8);
  endtask
  initial begin
    w(100000);
    fails++;
    test_done;
  end
  initial begin
    fails = 0;
    cmp_count = 0;
    {hresetn, hsel, htrans, haddr, hwrite, hwdata} = '0;
    hsize = 3'h2;
    {dac_load_strobe_n, dac_reset_n, reset_level_select} = 3'b101;
    gain_select = 1'b0;
    w(20);
    hresetn <= 1'b1;
    w(20);
    chan(10'h0, 10'h0);
    rd(8'h04, 32'h2, "status");
    dac_reset_n <= 1'b1;
    w(10);
    chan(10'h200, 10'h200);
    chk("ref", 32'h1, {31'h0, ref_drive_en});
    bus(1'b1, 8'h00, 32'h1);
    w(2);
    chk("ref", 32'h0, {31'h0, ref_drive_en});
    rd(8'h00, 32'h1, "ctrl");
    hsize <= 3'h0;
    bus(1'b1, 8'h00, 32'h0);
    hsize <= 3'h2;
    rd(8'h00, 32'h1, "ctrl_byte");
    bus(1'b1, 8'h00, 32'h0);
    rd(8'h10, 32'h0, "unmapped");
    gain_select <= 1'b1;
    w(8);
    chk("span", 32'h1, {31'h0, span_double});
    host_u.send(24'h31ffc0, 24, got);
    rd(8'h08, 32'h820003ff, "chan_a");
    host_u.send(24'h385540, 24, got);
    chk("daisy", 32'h31ffc0, {8'h0, got});
    w(20);
    chan(10'h200, 10'h200);
    pulse;
    chan(10'h3ff, 10'h155);
    dac_load_strobe_n <= 1'b0;
    host_u.send(24'h390000, 24, got);
    host_u.send(24'h31ffc0, 23, got);
    w(20);
    chan(10'h0, 10'h0);
    dac_load_strobe_n <= 1'b1;
    dac_reset_n <= 1'b0;
    w(8);
    chan(10'h200, 10'h200);
    host_u.send(24'h31ffc0, 24, got);
    w(20);
    pulse;
    chan(10'h200, 10'h200);
    dac_reset_n <= 1'b1;
    reset_level_select <= 1'b0;
    w(8);
    dac_reset_n <= 1'b0;
    w(8);
    chan(10'h0, 10'h0);
    dac_reset_n <= 1'b1;
    bus(1'b1, 8'h00, 32'h2);
    repeat (10) host_u.send(24'h31ffc0, 24, got);
    rd(8'h04, 32'h80d, "status");
    bus(1'b1, 8'h00, 32'h0);
    w(40);
    bus(1'b1, 8'h04, 32'h1);
    rd(8'h04, 32'h4, "status");
    test_done;
  end
endmodule
